// File: dv/dacwp_host.sv
`timescale 1ns/1ps
`default_nettype none
// host master, clock idles high
module dacwp_host (output var logic link_sclk = 1'b1, sync_n = 1'b1, sdata = 1'b0);
  // two wake edges with select high, then n bits msb first
  task automatic send(input logic [15:0] w, input int n);
    for (int i = -2; i < n; i++) begin
      sync_n = (i < 0);
      sdata = (i < 0) | w[15 - i];
      #80 link_sclk = 1'b0;
      #80 link_sclk = 1'b1;
    end
    sync_n = 1'b1;
    sdata = ~sdata;
    #280;
  endtask
endmodule
`default_nettype wire

// File: dv/dacwp_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dacwp_chk (input wire logic clock, rstn, sync_n, update_pulse, input wire dacwp_pkg::dacwp_setting_type setting);
  // one domain, system clock
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_MOVE: assert property ($changed(setting) |-> update_pulse) else $error("code moved");
  AST_MODE: assert property ($changed(setting.mode) |-> update_pulse) else $error("mode moved");
  AST_HOLD: assert property (update_pulse |=> $stable(setting) [*8]) else $error("unstable");
  AST_ONE: assert property (update_pulse |=> !update_pulse) else $error("long pulse");
  AST_IDLE: assert property (sync_n [*6] |-> !update_pulse) else $error("idle pulse");
  AST_ABORT: assert property (sync_n [*8] |=> $stable(setting)) else $error("idle change");
  AST_FRAME: assert property (update_pulse |-> !$past(sync_n, 8)) else $error("no frame");
  AST_RST: assert property ($rose(rstn) |-> setting == 10'h000 && !update_pulse) else $error("reset");
endmodule
bind dacwp_port dacwp_chk dacwp_chk_i(.clock, .rstn, .sync_n, .update_pulse, .setting);
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, rstn = 1'b0, update_pulse, link_sclk, sync_n, sdata;
  logic [9:0] setting, exp_q[$], last = 10'h000;
  logic [15:0] w;
  int fails = 0, comparisons = 0, seed = 32'h28F0;
  dacwp_port dacwp_port_i(.clock, .rstn, .link_sclk, .sync_n, .sdata, .setting, .update_pulse);
  dacwp_host dacwp_host_i(.link_sclk, .sync_n, .sdata);
  initial forever #25 clock = ~clock;
  task automatic cmp(string n, logic [9:0] e, s);
    comparisons++;
    if (s !== e) fails++;
    if (s !== e) $display("CHECK FAILED %s exp %h seen %h", n, e, s);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // each update takes the oldest note
  always @(negedge clock)
    if (update_pulse === 1'b1) cmp("setting", exp_q.size() ? exp_q.pop_front() : 'x, setting);
  initial begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    cmp("reset", 10'h000, setting);
    for (int k = 0; k < 8; k++) begin
      w = 16'($random(seed));
      w[13:12] = 2'(k);
      @(negedge clock);
      if (k == 3 || k == 6) begin
        dacwp_host_i.send(w, k == 3 ? 15 : 1);
        cmp("held", last, setting);
      end else begin
        exp_q.push_back(w[13:4]);
        last = w[13:4];
        dacwp_host_i.send(w, 16);
      end
      $display("test %0d", k);
    end
    cmp("pending", 10'h000, 10'(exp_q.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: hw/dacwp_pkg.sv
package dacwp_pkg;
  // frame geometry
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0] LAST_BIT_CNT = 5'h10;
  // field positions inside the received word (msb first on the wire)
  localparam int unsigned MODE_MSB = 13;
  localparam int unsigned MODE_LSB = 12;
  localparam int unsigned DATA_MSB = 11;
  localparam int unsigned DATA_LSB = 4;
  // reset values
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  // least frame select high time between frames
  localparam int unsigned SEL_HIGH_MIN_NS = 33;

  // operating modes
  typedef enum logic [1:0] {
    DACWP_MODE_NORMAL = 2'b00,
    DACWP_MODE_PD1 = 2'b01,
    DACWP_MODE_PD2 = 2'b10,
    DACWP_MODE_PD3 = 2'b11
  } dacwp_mode_type;

  // converter setting carried as one word
  typedef struct packed {
    dacwp_mode_type mode;
    logic [7:0] code;
  } dacwp_setting_type;

  // split a received word into its mode and code fields
  function automatic dacwp_setting_type dacwp_decode(input logic [15:0] word);
    dacwp_setting_type s;
    s.mode = dacwp_mode_type'(word[MODE_MSB:MODE_LSB]);
    s.code = word[DATA_MSB:DATA_LSB];
    return s;
  endfunction
endpackage

// File: hw/dacwp_port.sv
// Summary of operation
// - sixteen-bit shift register, bit per falling edge
// - frame select low enables shifting
// - sixteenth falling edge updates converter code
// - early frame select rise aborts write
// - word: two spare, mode, data, four spare
// - abort clears shifter, keeps code and mode
// - mode applied on same sixteenth edge
`timescale 1ns/1ps
`default_nettype none
module dacwp_port (
  // system clock and reset
  input wire logic clock,
  input wire logic rstn,
  // serial link from the host
  input wire logic link_sclk,
  input wire logic sync_n,
  input wire logic sdata,
  // converter setting, system domain
  output dacwp_pkg::dacwp_setting_type setting,
  output logic update_pulse
);
  import dacwp_pkg::*;

  // reset synchronised into the link domain, released on link edges
  logic lrst_a_r;
  logic lrst_b_r;
  always_ff @(negedge link_sclk or negedge rstn) begin
    if (!rstn) begin
      lrst_a_r <= 1'b0;
      lrst_b_r <= 1'b0;
    end else begin
      lrst_a_r <= 1'b1;
      lrst_b_r <= lrst_a_r;
    end
  end

  // link domain state: shifter, bit count, captured word, toggle
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] word_r, word_nxt;
  logic tog_r, tog_nxt;
  // frame select high clears count asynchronously, acting as abort
  logic frame_clr_n;
  assign frame_clr_n = rstn & ~sync_n;

  // next values on each falling link edge inside a frame
  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    tog_nxt = tog_r;
    if (cnt_r < LAST_BIT_CNT) begin
      shift_nxt = {shift_r[14:0], sdata};
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == LAST_BIT_CNT - 5'h01) begin
        word_nxt = {shift_r[14:0], sdata};
        tog_nxt = ~tog_r;
      end
    end
  end

  // shifter and count reset whenever frame select is high
  always_ff @(negedge link_sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // completed word and its event toggle survive aborts
  always_ff @(negedge link_sclk or negedge rstn) begin
    if (!rstn) begin
      word_r <= 16'h0000;
      tog_r <= 1'b0;
    end else if (lrst_b_r && !sync_n) begin
      word_r <= word_nxt;
      tog_r <= tog_nxt;
    end
  end

  // system domain: toggle synchroniser and applied setting
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  logic tog_s1_nxt, tog_s2_nxt, tog_s3_nxt;
  dacwp_setting_type set_r, set_nxt;
  logic upd_r, upd_nxt;

  // apply mode and code together when a full word arrives
  always_comb begin
    tog_s1_nxt = tog_r;
    tog_s2_nxt = tog_s1_r;
    tog_s3_nxt = tog_s2_r;
    upd_nxt = tog_s2_r ^ tog_s3_r;
    set_nxt = set_r;
    if (upd_nxt) begin
      set_nxt = dacwp_decode(word_r);
    end
  end

  // registers of the system domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      upd_r <= 1'b0;
      set_r <= '{mode: DACWP_MODE_NORMAL, code: CODE_RST};
    end else begin
      tog_s1_r <= tog_s1_nxt;
      tog_s2_r <= tog_s2_nxt;
      tog_s3_r <= tog_s3_nxt;
      upd_r <= upd_nxt;
      set_r <= set_nxt;
    end
  end

  // outputs from flip-flops
  assign setting = set_r;
  assign update_pulse = upd_r;
endmodule
`default_nettype wire
